// ===== src/fspc_core.sv
// Flash self-program sequencer: control register, store window, erase,
// page write, lock programming, section blocking and CPU stall.
// Assumes the core raises store_exec for one cycle per store instruction
// and that the flash array itself sits outside, driven by the pins below.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_cfg.svh"

// Function
// - Buffer is loaded one word per store, before erase or after.
// - Pattern X0000011 plus store within four cycles starts page erase.
// - Erase of stalling section halts the CPU; other erase leaves it readable.
// - Pattern 00000001 plus store loads data pair at word index.
// - Buffer clears after page write, read re-enable, and reset.
// - An EEPROM write during page loading discards loaded buffer data.
// - Pattern X0000101 plus store within four cycles starts page write.
// - Write to stalling section halts the CPU for its whole duration.
// - Ready interrupt asserts continuously while enabled and store-enable clear.
// - Concurrent-read section reads blocked during any erase or write.
// - Section-busy flag stays set while concurrent-read section is busy.
// - Pattern X0001001 plus store within four cycles sets boot locks.
// - Each zero in data bits 5..2 programs its boot lock bit.
// - Whole flash stays readable while lock bits are programmed.
// - EEPROM write in progress blocks all flash programming operations.
// - Store-enable clears after a load or re-enable store, at the end of erase, write or lock, or after four idle cycles.
// - Any low five bit pattern other than the legal five is ignored.
// - Read re-enable during loading aborts the load and drops its data.
module fspc_core
  import fspc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `FSPC_PROG_CYC
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        store_exec,
  input  wire logic        eeprom_write_busy,
  output logic             ready_irq,
  output logic             cpu_halt,
  output logic             concurrent_read_block,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [`FSPC_PAGE_BITS-1:0] flash_page,
  output logic [`FSPC_WORD_BITS-1:0] flash_word_idx,
  output logic [15:0]      flash_wdata,
  output logic [3:0]       boot_lock_bits
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    fspc_state_e                   state;
    fspc_op_e                      op;
    logic [2:0]                    win_cnt;
    logic [22:0]                   prog_cnt;
    logic                          irq_en;
    logic                          busy;
    logic                          stall;
    logic [`FSPC_PAGE_BITS-1:0]    page;
    logic [`FSPC_WORD_BITS-1:0]    word_idx;
    logic [23:0]                   pointer;
    logic [15:0]                   data_pair;
    logic [3:0]                    locks;
    logic [7:0]                    rdata;
    logic                          loading;
    logic                          erase_out;
    logic                          write_out;
  } fspc_state_s;

  fspc_state_s s_q;
  fspc_state_s s_d;

  logic [`FSPC_PAGE_BITS-1:0] ptr_page;
  logic [`FSPC_WORD_BITS-1:0] ptr_word;
  logic                       buf_clear;
  logic                       buf_wr;
  logic [15:0]                buf_rd_word;
  logic                       buf_any;
  logic                       store_en;
  logic                       ctrl_wr;
  logic [4:0]                 cmd;

  // Pointer holds byte address: bit 0 ignored, then word, then page
  assign ptr_word = s_q.pointer[`FSPC_WORD_BITS:1];
  assign ptr_page = s_q.pointer[`FSPC_WORD_BITS+`FSPC_PAGE_BITS:`FSPC_WORD_BITS+1];
  assign store_en = (s_q.state != FSPC_IDLE);
  assign ctrl_wr  = reg_wr && (reg_addr == `FSPC_ADDR_CTRL);
  assign cmd      = reg_wdata[4:0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    buf_clear = 1'b0;
    buf_wr    = 1'b0;

    // Plain register writes for pointer and data pair
    if (reg_wr) begin
      unique case (reg_addr)
        `FSPC_ADDR_PTR_LO:  s_d.pointer[7:0]   = reg_wdata;
        `FSPC_ADDR_PTR_HI:  s_d.pointer[15:8]  = reg_wdata;
        `FSPC_ADDR_PTR_EXT: s_d.pointer[23:16] = reg_wdata;
        `FSPC_ADDR_DATA_LO: s_d.data_pair[7:0]  = reg_wdata;
        `FSPC_ADDR_DATA_HI: s_d.data_pair[15:8] = reg_wdata;
        default: ;
      endcase
    end

    // Interrupt enable is writable at any time
    if (ctrl_wr) begin
      s_d.irq_en = reg_wdata[`FSPC_BIT_IRQ_EN];
    end

    unique case (s_q.state)
      FSPC_IDLE: begin
        // Programming is locked out while EEPROM writes
        if (ctrl_wr && !eeprom_write_busy) begin
          s_d.win_cnt = `FSPC_WINDOW_CYC;
          s_d.state   = FSPC_ARMED;
          unique case (cmd)
            `FSPC_CMD_LOAD:  s_d.op = FSPC_OP_LOAD;
            `FSPC_CMD_ERASE: s_d.op = FSPC_OP_ERASE;
            `FSPC_CMD_WRITE: s_d.op = FSPC_OP_WRITE;
            `FSPC_CMD_LOCK:  s_d.op = FSPC_OP_LOCK;
            `FSPC_CMD_REEN:  s_d.op = FSPC_OP_REEN;
            default:         s_d.state = FSPC_IDLE;
          endcase
        end
      end
      FSPC_ARMED: begin
        if (store_exec && !eeprom_write_busy) begin
          s_d.state = FSPC_IDLE;
          unique case (s_q.op)
            FSPC_OP_LOAD: begin
              buf_wr      = 1'b1;
              s_d.loading = 1'b1;
              s_d.busy    = 1'b0;
            end
            FSPC_OP_ERASE: begin
              s_d.page      = ptr_page;
              s_d.state     = FSPC_ERASE;
              s_d.prog_cnt  = 23'(PROG_CYCLES);
              s_d.erase_out = 1'b1;
            end
            FSPC_OP_WRITE: begin
              s_d.page      = ptr_page;
              s_d.state     = FSPC_WRITE;
              s_d.prog_cnt  = 23'(PROG_CYCLES);
              s_d.write_out = 1'b1;
            end
            FSPC_OP_LOCK: begin
              // Zero data bits program locks; programmed bits return only on reset
              s_d.locks    = s_q.locks & s_q.data_pair[5:2];
              s_d.state    = FSPC_LOCK;
              s_d.prog_cnt = 23'(PROG_CYCLES);
            end
            FSPC_OP_REEN: begin
              s_d.busy    = 1'b0;
              buf_clear   = 1'b1;
              s_d.loading = 1'b0;
            end
            default: ;
          endcase
          // Busy set for erase and write; stall decided from the pointer page
          if (s_q.op == FSPC_OP_ERASE || s_q.op == FSPC_OP_WRITE) begin
            s_d.busy  = 1'b1;
            s_d.stall = (ptr_page >= `FSPC_SECT_SPLIT);
          end
        end else if (s_q.win_cnt == 3'd1) begin
          s_d.state = FSPC_IDLE;
        end else begin
          s_d.win_cnt = s_q.win_cnt - 3'd1;
        end
      end
      FSPC_ERASE, FSPC_WRITE, FSPC_LOCK: begin
        // Store-enable stays up until the operation ends
        s_d.erase_out = 1'b0;
        s_d.write_out = 1'b0;
        if (s_q.prog_cnt <= 23'd1) begin
          s_d.state = FSPC_IDLE;
          s_d.stall = 1'b0;
          if (s_q.state == FSPC_WRITE) begin
            buf_clear   = 1'b1;
            s_d.loading = 1'b0;
          end
        end else begin
          s_d.prog_cnt = s_q.prog_cnt - 23'd1;
        end
      end
      default: s_d.state = FSPC_IDLE;
    endcase

    // EEPROM activity in the middle of a load sequence loses the data
    if (eeprom_write_busy && s_q.loading) begin
      buf_clear   = 1'b1;
      s_d.loading = 1'b0;
    end

    // Read data, one cycle after the strobe
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `FSPC_ADDR_CTRL: begin
          s_d.rdata[`FSPC_BIT_IRQ_EN]   = s_q.irq_en;
          s_d.rdata[`FSPC_BIT_BUSY]     = s_q.busy;
          s_d.rdata[`FSPC_BIT_STORE_EN] = store_en;
          s_d.rdata[`FSPC_BIT_ERASE]    = store_en && (s_q.op == FSPC_OP_ERASE);
          s_d.rdata[`FSPC_BIT_PAGE_WR]  = store_en && (s_q.op == FSPC_OP_WRITE);
          s_d.rdata[`FSPC_BIT_LOCK_SET] = store_en && (s_q.op == FSPC_OP_LOCK);
          s_d.rdata[`FSPC_BIT_REENABLE] = store_en && (s_q.op == FSPC_OP_REEN);
        end
        `FSPC_ADDR_PTR_LO:  s_d.rdata = s_q.pointer[7:0];
        `FSPC_ADDR_PTR_HI:  s_d.rdata = s_q.pointer[15:8];
        `FSPC_ADDR_PTR_EXT: s_d.rdata = s_q.pointer[23:16];
        `FSPC_ADDR_DATA_LO: s_d.rdata = s_q.data_pair[7:0];
        `FSPC_ADDR_DATA_HI: s_d.rdata = s_q.data_pair[15:8];
        `FSPC_ADDR_LOCKS:   s_d.rdata = {2'b11, s_q.locks, 2'b11};
        default:            s_d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: FSPC_IDLE, op: FSPC_OP_LOAD, locks: `FSPC_LOCK_RST,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Buffer is emptied on reset by its own reset
  fspc_page_buf u_buf (
    .clock      (clock),
    .rst_n      (rst_n),
    .clear      (buf_clear),
    .wr_en      (buf_wr),
    .wr_idx     (ptr_word),
    .wr_word    (s_q.data_pair),
    .rd_idx     (flash_word_idx),
    .rd_word    (buf_rd_word),
    .any_loaded (buf_any)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Level interrupt: no edge is lost if software polls late
  assign ready_irq             = s_q.irq_en && !store_en;
  assign cpu_halt              = s_q.stall;
  // Lock programming leaves the whole array readable
  assign concurrent_read_block = s_q.busy;
  assign flash_erase           = s_q.erase_out;
  assign flash_write           = s_q.write_out;
  assign flash_page            = s_q.page;
  assign flash_word_idx        = ptr_word;
  assign flash_wdata           = buf_any ? buf_rd_word : 16'hFFFF;
  assign boot_lock_bits        = s_q.locks;
  assign reg_rdata             = s_q.rdata;
endmodule
`default_nettype wire

// ===== src/fspc_cfg.svh
// Constants for the flash self-program control block.
// Assumes inclusion by the package and the modules; definitions only.
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH

// Register offsets on the plain register port
`define FSPC_ADDR_CTRL      4'h0
`define FSPC_ADDR_PTR_LO    4'h1
`define FSPC_ADDR_PTR_HI    4'h2
`define FSPC_ADDR_PTR_EXT   4'h3
`define FSPC_ADDR_DATA_LO   4'h4
`define FSPC_ADDR_DATA_HI   4'h5
`define FSPC_ADDR_LOCKS     4'h6

// Control register bit positions
`define FSPC_BIT_STORE_EN   0
`define FSPC_BIT_ERASE      1
`define FSPC_BIT_PAGE_WR    2
`define FSPC_BIT_LOCK_SET   3
`define FSPC_BIT_REENABLE   4
`define FSPC_BIT_BUSY       6
`define FSPC_BIT_IRQ_EN     7

// Legal low five bit command patterns
`define FSPC_CMD_LOAD       5'h01
`define FSPC_CMD_ERASE      5'h03
`define FSPC_CMD_WRITE      5'h05
`define FSPC_CMD_LOCK       5'h09
`define FSPC_CMD_REEN       5'h11

// Geometry: 128 words per page, 512 pages
`define FSPC_WORD_BITS      7
`define FSPC_PAGE_BITS      9
`define FSPC_BUF_WORDS      128
`define FSPC_SECT_SPLIT     9'h1E0

// Timing
`define FSPC_WINDOW_CYC     3'd4
`define FSPC_CLK_HZ         20000000
`define FSPC_PROG_TIME_US   3700
`define FSPC_PROG_CYC       ((`FSPC_PROG_TIME_US * (`FSPC_CLK_HZ / 1000)) / 1000)

`define FSPC_CTRL_RST       8'h00
`define FSPC_LOCK_RST       4'hF

`endif

// ===== src/fspc_pkg.sv
// Types for the flash self-program control block.
// Assumes the constant header is on the include path.
`include "fspc_cfg.svh"

package fspc_pkg;
  typedef enum logic [2:0] {
    FSPC_IDLE,
    FSPC_ARMED,
    FSPC_ERASE,
    FSPC_WRITE,
    FSPC_LOCK
  } fspc_state_e;

  typedef enum logic [2:0] {
    FSPC_OP_LOAD,
    FSPC_OP_ERASE,
    FSPC_OP_WRITE,
    FSPC_OP_LOCK,
    FSPC_OP_REEN
  } fspc_op_e;
endpackage

// ===== src/fspc_page_buf.sv
// Temporary page buffer with per-word written marks.
// Assumes one clock; clear and write never both matter (clear wins).
`timescale 1ns/1ps
`default_nettype none
`include "fspc_cfg.svh"

module fspc_page_buf
  import fspc_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        clear,
  input  wire logic                        wr_en,
  input  wire logic [`FSPC_WORD_BITS-1:0]  wr_idx,
  input  wire logic [15:0]                 wr_word,
  input  wire logic [`FSPC_WORD_BITS-1:0]  rd_idx,
  output logic      [15:0]                 rd_word,
  output logic                             any_loaded
);
  logic [15:0]                 mem [`FSPC_BUF_WORDS];
  logic [`FSPC_BUF_WORDS-1:0]  valid_q;

  // Erased flash reads as all ones, so an unloaded word writes as ones
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= '0;
    end else if (clear) begin
      valid_q <= '0;
    end else if (wr_en) begin
      valid_q[wr_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_en && !clear) begin
      mem[wr_idx] <= wr_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_word <= 16'hFFFF;
    end else begin
      rd_word <= valid_q[rd_idx] ? mem[rd_idx] : 16'hFFFF;
    end
  end

  assign any_loaded = |valid_q;
endmodule
`default_nettype wire

// ===== verif/fspc_core_sva.sv
// Port assertions for the flash self-program sequencer.
// Assumes one clock domain and the same PROG_CYCLES as the bound core.
`timescale 1ns/1ps
`default_nettype none
module fspc_core_sva #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       ready_irq,
  input wire logic       cpu_halt,
  input wire logic       concurrent_read_block,
  input wire logic       flash_erase,
  input wire logic       flash_write,
  input wire logic [8:0] flash_page,
  input wire logic [3:0] boot_lock_bits
);
  // -------------------------------------------------------------------
  // Helper: length of the current stall
  // -------------------------------------------------------------------
  logic [15:0] halt_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) halt_cnt_q <= 16'h0000;
    else halt_cnt_q <= cpu_halt ? halt_cnt_q + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  erase_blocks_a: assert property (
    flash_erase |-> concurrent_read_block) else $error("erase without read block");
  write_blocks_a: assert property (
    flash_write |-> concurrent_read_block) else $error("write without read block");
  halt_blocks_a: assert property (
    cpu_halt |-> concurrent_read_block) else $error("stall without read block");
  halt_page_a: assert property (
    cpu_halt |-> flash_page >= 9'h1E0) else $error("stall on concurrent page");
  erase_irq_a: assert property (
    flash_erase |-> !ready_irq) else $error("irq at erase start");
  halt_irq_a: assert property (
    cpu_halt |-> !ready_irq) else $error("irq while stalled");
  erase_pulse_a: assert property (
    flash_erase |=> !flash_erase) else $error("erase pulse too long");
  write_pulse_a: assert property (
    flash_write |=> !flash_write) else $error("write pulse too long");
  lock_only_clear_a: assert property (
    (boot_lock_bits & ~$past(boot_lock_bits)) == 4'h0) else $error("lock bit set back");
  halt_len_a: assert property (
    halt_cnt_q <= PROG_CYCLES + 1) else $error("stall too long");
endmodule

bind fspc_core fspc_core_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .clock(clock), .rst_n(rst_n), .ready_irq(ready_irq), .cpu_halt(cpu_halt),
  .concurrent_read_block(concurrent_read_block), .flash_erase(flash_erase),
  .flash_write(flash_write), .flash_page(flash_page), .boot_lock_bits(boot_lock_bits)
);
`default_nettype wire

// ===== verif/fspc_cpu_model.sv
// Processor side: issues one store pulse a set number of cycles after req.
// Assumes req is a one-cycle pulse; a halted core executes nothing.
`timescale 1ns/1ps
`default_nettype none
module fspc_cpu_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       req,
  input  wire logic [2:0] dly,
  input  wire logic       cpu_halt,
  output logic            store_exec
);
  logic [2:0] cnt_q;
  logic       busy_q;
  // Takes no interrupts, so no vector fetch reaches the blocked section
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q     <= 1'b0;
      cnt_q      <= 3'h0;
      store_exec <= 1'b0;
    end else begin
      store_exec <= 1'b0;
      if (req && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= dly;
      end else if (busy_q && !cpu_halt) begin
        if (cnt_q == 3'h0) begin
          store_exec <= 1'b1;
          busy_q     <= 1'b0;
        end else cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/fspc_core_tb.sv
// Self-checking bench for the self-program sequencer.
// Assumes the core's bound checker and the processor model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_cfg.svh"
module fspc_core_tb
  import fspc_pkg::*;
;
  logic        clock, rst_n, reg_wr, reg_rd, store_exec, eeprom_write_busy;
  logic        ready_irq, cpu_halt, concurrent_read_block, flash_erase, flash_write;
  logic        req;
  logic [2:0]  cpu_dly;
  logic [3:0]  reg_addr, boot_lock_bits;
  logic [7:0]  reg_wdata, reg_rdata, q;
  logic [8:0]  flash_page;
  logic [6:0]  flash_word_idx;
  logic [15:0] flash_wdata;
  int          miscompares, n_checks;
  bit          hit;
  fspc_core #(.PROG_CYCLES(20)) dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_exec(store_exec),
    .eeprom_write_busy(eeprom_write_busy), .ready_irq(ready_irq), .cpu_halt(cpu_halt),
    .concurrent_read_block(concurrent_read_block), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page(flash_page), .flash_word_idx(flash_word_idx),
    .flash_wdata(flash_wdata), .boot_lock_bits(boot_lock_bits));
  fspc_cpu_model u_cpu (.clock(clock), .rst_n(rst_n), .req(req), .dly(cpu_dly),
    .cpu_halt(cpu_halt), .store_exec(store_exec));
  always #25 clock = ~clock;
  // -------------------------------------------------------------------
  // Bus and check tasks
  // -------------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Control write with the store following dly+2 cycles later
  task automatic cmd(input logic [7:0] d, input logic [2:0] dly);
    @(posedge clock);
    reg_addr <= `FSPC_ADDR_CTRL;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    req <= 1'b1;
    cpu_dly <= dly;
    @(posedge clock);
    reg_wr <= 1'b0;
    req <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40; i++) begin
      rd(`FSPC_ADDR_CTRL);
      if (q[0] === 1'b0) break;
    end
    chk(i < 40, "store enable stuck");
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wait_ev(input bit wop);
    int i;
    hit = 1'b0;
    for (i = 0; i < 8 && !hit; i++) begin
      @(posedge clock);
      #1 hit = ((wop ? flash_write : flash_erase) === 1'b1);
    end
  endtask
  task automatic ptr(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ext);
    wr(`FSPC_ADDR_PTR_LO, lo);
    wr(`FSPC_ADDR_PTR_HI, hi);
    wr(`FSPC_ADDR_PTR_EXT, ext);
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_basic();
    rd(`FSPC_ADDR_CTRL);
    chk(q === 8'h00 && boot_lock_bits === 4'hF, "reset values");
    chk(flash_wdata === 16'hFFFF && ready_irq === 1'b0, "reset outputs");
    ptr(8'h0A, 8'h00, 8'h00);
    wr(`FSPC_ADDR_DATA_LO, 8'h34);
    wr(`FSPC_ADDR_DATA_HI, 8'h12);
    cmd(8'h01, 3'd2);
    wait_idle();
    chk(flash_word_idx === 7'd5 && flash_wdata === 16'h1234, "late store lost");
    wr(`FSPC_ADDR_PTR_LO, 8'h0C);
    cmd(8'h01, 3'd3);
    wait_idle();
    chk(flash_wdata === 16'hFFFF, "store after window taken");
    cmd(8'h07, 3'd0);
    wait_idle();
    rd(`FSPC_ADDR_CTRL);
    chk(q === 8'h00 && concurrent_read_block === 1'b0, "bad pattern acted");
    $display("done: load and window");
  endtask
  task automatic t_erase();
    ptr(8'h00, 8'hE0, 8'h01);
    cmd(8'h83, 3'd0);
    wait_ev(1'b0);
    chk(hit && flash_page === 9'h1E0 && cpu_halt === 1'b1, "erase stall");
    chk(concurrent_read_block === 1'b1 && ready_irq === 1'b0, "erase block");
    rd(`FSPC_ADDR_CTRL);
    chk(q === 8'hC3, "status during erase");
    wait_idle();
    chk(cpu_halt === 1'b0 && ready_irq === 1'b1, "ready after erase");
    chk(concurrent_read_block === 1'b1, "busy dropped early");
    wr(`FSPC_ADDR_PTR_LO, 8'h0A);
    repeat (2) @(posedge clock);
    #1 chk(flash_wdata === 16'h1234, "erase lost buffer");
    cmd(8'h11, 3'd0);
    wait_idle();
    chk(concurrent_read_block === 1'b0 && flash_wdata === 16'hFFFF, "reenable");
    $display("done: erase");
  endtask
  task automatic t_eeprom();
    cmd(8'h01, 3'd0);
    wait_idle();
    chk(flash_wdata === 16'h1234, "reload");
    @(posedge clock);
    eeprom_write_busy <= 1'b1;
    cmd(8'h05, 3'd0);
    wait_ev(1'b1);
    chk(!hit, "write during eeprom busy");
    @(posedge clock);
    eeprom_write_busy <= 1'b0;
    wait_idle();
    chk(flash_wdata === 16'hFFFF, "buffer kept over eeprom write");
    $display("done: eeprom interlock");
  endtask
  task automatic t_write();
    cmd(8'h01, 3'd1);
    wait_idle();
    wr(`FSPC_ADDR_PTR_LO, 8'h00);
    cmd(8'h05, 3'd1);
    wait_ev(1'b1);
    chk(hit && flash_page === 9'h1E0 && cpu_halt === 1'b1, "write stall");
    wait_idle();
    wr(`FSPC_ADDR_PTR_LO, 8'h0A);
    repeat (2) @(posedge clock);
    #1 chk(flash_wdata === 16'hFFFF && concurrent_read_block === 1'b1, "after write");
    cmd(8'h11, 3'd0);
    wait_idle();
    $display("done: page write");
  endtask
  task automatic t_lock();
    ptr(8'h01, 8'h00, 8'h00);
    wr(`FSPC_ADDR_DATA_LO, 8'hD7);
    cmd(8'h09, 3'd0);
    wait_idle();
    chk(boot_lock_bits === 4'h5, "first lock");
    wr(`FSPC_ADDR_DATA_LO, 8'hFB);
    cmd(8'h09, 3'd2);
    wait_idle();
    chk(boot_lock_bits === 4'h4 && concurrent_read_block === 1'b0, "second lock");
    rd(`FSPC_ADDR_LOCKS);
    chk(q === 8'hD3, "lock readback");
    $display("done: lock bits");
  endtask
  task automatic t_reset();
    ptr(8'h0A, 8'h00, 8'h00);
    wr(`FSPC_ADDR_DATA_LO, 8'h34);
    cmd(8'h01, 3'd0);
    wait_idle();
    chk(flash_wdata === 16'h1234, "load before reset");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk(flash_wdata === 16'hFFFF && boot_lock_bits === 4'hF, "reset kept buffer");
    $display("done: mid-run reset");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(20000 * 50);
    miscompares++;
    finish_test();
  end
  initial begin
    {clock, rst_n, reg_wr, reg_rd, eeprom_write_busy, req} = 6'h00;
    {reg_addr, reg_wdata, cpu_dly} = 15'h0000;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_basic();
    t_erase();
    t_eeprom();
    t_write();
    t_lock();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
